// ===== fsh_pkg.sv
package fsh_pkg;

  // opcodes
  localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_READ_STATUS = 8'h05;
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_FAST_READ = 8'h0B;
  localparam logic [7:0] OP_DUAL_OUT_READ = 8'h3B;
  localparam logic [7:0] OP_DUAL_IO_READ = 8'hBB;

  // status byte layout
  localparam int unsigned SB_STATUS_WRITE_DISABLE = 7;
  localparam int unsigned SB_QUAD_ENABLE = 6;
  localparam int unsigned SB_BP_HI = 5;
  localparam int unsigned SB_BP_LO = 2;
  localparam int unsigned SB_WRITE_ENABLE_LATCH = 1;
  localparam int unsigned SB_WRITE_IN_PROGRESS = 0;
  localparam logic [7:0] STATUS_RESET = 8'h00;

  // phase lengths in serial clocks or bits
  localparam logic [4:0] CMD_LAST = 5'h07;
  localparam logic [4:0] ADDR_LAST_SINGLE = 5'h17;
  localparam logic [4:0] ADDR_LAST_DUAL = 5'h0B;
  localparam logic [4:0] STATUS_WRITE_CMD_BITS_SHORT = 5'h08;
  localparam logic [4:0] STATUS_WRITE_CMD_BITS_LONG = 5'h10;
  localparam logic [4:0] COUNT_MAX = 5'h1F;
  localparam logic [4:0] DUMMY_FAST = 5'h08;
  localparam logic [4:0] DUMMY_DUAL_OUT = 5'h08;
  localparam logic [4:0] DUMMY_DUAL_IO = 5'h04;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // timing
  localparam int unsigned MCLK_PERIOD_NS = 25;
  localparam int unsigned STATUS_WRITE_TIME_NS = 10000000;
  localparam int unsigned STATUS_WRITE_CYCLES = STATUS_WRITE_TIME_NS / MCLK_PERIOD_NS;

  // array size
  localparam int unsigned MEM_ADDR_BITS = 18;

  // synchroniser reset levels: {wp_n, io1, io0, sclk, cs_n}
  localparam logic [4:0] PIN_RESET = 5'h11;

  typedef enum logic [2:0] {
    ST_CMD = 3'b000,
    ST_ADDR = 3'b001,
    ST_DUMMY = 3'b010,
    ST_DATA = 3'b011,
    ST_STATUS_WRITE_CMD = 3'b100,
    ST_STATUS = 3'b101,
    ST_HOLD = 3'b110
  } fsh_state_e;

endpackage

// ===== fsh_mem_if.sv
interface fsh_mem_if #(
  parameter int unsigned AW = fsh_pkg::MEM_ADDR_BITS
);
  logic [AW-1:0] raddr;
  logic [7:0] rdata;

  modport reader (output raddr, input rdata);
  modport array (input raddr, output rdata);
endinterface

// ===== fsh_sync.sv
module fsh_sync #(
  parameter int unsigned W = 5,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // pins
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] meta;

  ////////////////////////////////////////////////////////////////////////////
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge mclk_i) begin
      if (rst_i) begin
        meta[i] <= RST_VAL[i];
        sync_o[i] <= RST_VAL[i];
      end else if (ce_i) begin
        meta[i] <= async_i[i];
        sync_o[i] <= meta[i];
      end
    end
  end
endmodule

// ===== fsh_mem.sv
module fsh_mem #(
  parameter int unsigned AW = fsh_pkg::MEM_ADDR_BITS
) (
  // clock
  input wire logic mclk_i,
  input wire logic ce_i,
  // preload port
  input wire logic load_i,
  input wire logic [AW-1:0] load_addr_i,
  input wire logic [7:0] load_data_i,
  // read side
  fsh_mem_if.array rd
);
  logic [7:0] mem [2**AW];

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk_i) begin
    if (ce_i) begin
      if (load_i) begin
        mem[load_addr_i] <= load_data_i;
      end
      rd.rdata <= mem[rd.raddr];
    end
  end
endmodule

// ===== fsh_flash_core.sv
module fsh_flash_core #(
  parameter int unsigned AW = fsh_pkg::MEM_ADDR_BITS,
  parameter int unsigned WRITE_CYCLES = fsh_pkg::STATUS_WRITE_CYCLES
) (
  // clock, reset, enable
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // serial pins
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic [1:0] io_line_i,
  input wire logic write_protect_pin_n_i,
  output logic [1:0] io_line_o,
  output logic [1:0] io_line_oe_o,
  // array preload
  input wire logic mem_load_i,
  input wire logic [AW-1:0] mem_load_addr_i,
  input wire logic [7:0] mem_load_data_i,
  // protection state
  output logic [7:0] status_o,
  output logic hardware_protect_mode_o,
  output logic software_protect_mode_o,
  output logic [3:0] block_protect_o
);
  import fsh_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and edges
  logic [4:0] pins;
  logic s_cs_n;
  logic s_sclk;
  logic [1:0] s_io;
  logic s_wp_n;
  logic sclk_q;
  logic cs_q;

  fsh_sync #(
    .W(5),
    .RST_VAL(PIN_RESET)
  ) u_sync (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .async_i({write_protect_pin_n_i, io_line_i, sclk_i, cs_n_i}),
    .sync_o(pins)
  );

  assign s_cs_n = pins[0];
  assign s_sclk = pins[1];
  assign s_io = pins[3:2];
  assign s_wp_n = pins[4];

  wire sclk_rise = s_sclk & ~sclk_q;
  wire sclk_fall = ~s_sclk & sclk_q;
  wire cs_rise = s_cs_n & ~cs_q;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      sclk_q <= 1'b0;
      cs_q <= 1'b1;
    end else if (ce_i) begin
      sclk_q <= s_sclk;
      cs_q <= s_cs_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // array
  fsh_mem_if #(.AW(AW)) mem_bus ();

  fsh_mem #(
    .AW(AW)
  ) u_mem (
    .mclk_i(mclk_i),
    .ce_i(ce_i),
    .load_i(mem_load_i),
    .load_addr_i(mem_load_addr_i),
    .load_data_i(mem_load_data_i),
    .rd(mem_bus.array)
  );

  ////////////////////////////////////////////////////////////////////////////
  // state
  fsh_state_e st;
  logic [4:0] cnt;
  logic [7:0] op;
  logic [23:0] addr_sh;
  logic [AW-1:0] mem_addr;
  logic dual;
  logic [7:0] byte_sh;
  logic [3:0] left;
  logic [7:0] wr_sh;
  logic status_write_disable;
  logic quad_enable;
  logic [3:0] block_protect_bits;
  logic write_enable_latch;
  logic write_in_progress;
  logic [31:0] timer;

  assign mem_bus.raddr = mem_addr;

  function automatic logic [4:0] dummy_clks(input logic [7:0] o);
    case (o)
      OP_FAST_READ: dummy_clks = DUMMY_FAST;
      OP_DUAL_OUT_READ: dummy_clks = DUMMY_DUAL_OUT;
      OP_DUAL_IO_READ: dummy_clks = DUMMY_DUAL_IO;
      default: dummy_clks = 5'h00;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // decode
  wire [7:0] status = {status_write_disable, quad_enable, block_protect_bits,
                       write_enable_latch, write_in_progress};
  // quad enable takes the protect pin out of hardware protection
  wire hardware_protect_mode = status_write_disable & ~s_wp_n & ~quad_enable;
  wire [7:0] next_op = {op[6:0], s_io[0]};
  wire cmd_done = (st == ST_CMD) && sclk_rise && (cnt == CMD_LAST);
  wire op_is_read = (next_op == OP_READ);
  wire op_is_fast = (next_op == OP_FAST_READ);
  wire op_is_dout = (next_op == OP_DUAL_OUT_READ);
  wire op_is_dio = (next_op == OP_DUAL_IO_READ);
  wire busy_reject = write_in_progress & (op_is_fast | op_is_dout | op_is_dio);
  wire [23:0] next_addr_sh = dual ? {addr_sh[21:0], s_io[1], s_io[0]}
                                  : {addr_sh[22:0], s_io[0]};
  wire addr_done = (st == ST_ADDR) && sclk_rise &&
                   (cnt == (dual ? ADDR_LAST_DUAL : ADDR_LAST_SINGLE));
  wire [4:0] dummy_n = dummy_clks(op);
  wire dummy_done = (st == ST_DUMMY) && sclk_rise && (cnt == dummy_n - 5'h01);
  wire [4:0] cnt_sat = (cnt == COUNT_MAX) ? cnt : cnt + 5'h01;
  // latch set only by an exactly 8-bit write enable frame
  wire wel_set = cs_rise && (st == ST_HOLD) && (op == OP_WRITE_ENABLE) &&
                 (cnt == 5'h00) && !write_in_progress;
  wire wel_clr = cs_rise && (st == ST_HOLD) && (op == OP_WRITE_DISABLE) &&
                 (cnt == 5'h00) && !write_in_progress;
  wire status_write_cmd_ok = cs_rise && (st == ST_STATUS_WRITE_CMD) &&
                 ((cnt == STATUS_WRITE_CMD_BITS_SHORT) || (cnt == STATUS_WRITE_CMD_BITS_LONG)) &&
                 write_enable_latch &&
                 !hardware_protect_mode &&
                 !write_in_progress;
  wire [7:0] src_byte = (st == ST_STATUS) ? status : mem_bus.rdata;
  wire [7:0] out_byte = (left == 4'h0) ? src_byte : byte_sh;
  wire [3:0] next_left = ((left == 4'h0) ? BYTE_BITS : left) - (dual ? 4'h2 : 4'h1);
  wire shifting = sclk_fall && ((st == ST_DATA) || (st == ST_STATUS));

  ////////////////////////////////////////////////////////////////////////////
  // command sequencer
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      st <= ST_CMD;
      cnt <= 5'h00;
      op <= 8'h00;
      addr_sh <= 24'h000000;
      mem_addr <= '0;
      dual <= 1'b0;
      byte_sh <= 8'h00;
      left <= 4'h0;
      wr_sh <= 8'h00;
      io_line_o <= 2'h0;
      io_line_oe_o <= 2'h0;
    end else if (ce_i) begin
      if (s_cs_n) begin
        st <= ST_CMD;
        cnt <= 5'h00;
        dual <= 1'b0;
        io_line_oe_o <= 2'h0;
      end else if (sclk_rise) begin
        case (st)
          ST_CMD: begin
            op <= next_op;
            cnt <= cnt + 5'h01;
            if (cmd_done) begin
              cnt <= 5'h00;
              left <= 4'h0;
              if (busy_reject) begin
                st <= ST_HOLD;
              end else if (op_is_read || op_is_fast || op_is_dout) begin
                st <= ST_ADDR;
              end else if (op_is_dio) begin
                st <= ST_ADDR;
                dual <= 1'b1;
              end else if (next_op == OP_READ_STATUS) begin
                st <= ST_STATUS;
              end else if (next_op == OP_WRITE_STATUS) begin
                st <= ST_STATUS_WRITE_CMD;
              end else begin
                st <= ST_HOLD;
              end
            end
          end
          ST_ADDR: begin
            addr_sh <= next_addr_sh;
            cnt <= cnt + 5'h01;
            if (addr_done) begin
              cnt <= 5'h00;
              mem_addr <= next_addr_sh[AW-1:0];
              dual <= (op == OP_DUAL_OUT_READ) || (op == OP_DUAL_IO_READ);
              st <= (dummy_n == 5'h00) ? ST_DATA : ST_DUMMY;
            end
          end
          ST_DUMMY: begin
            // dummy line levels are ignored
            cnt <= cnt + 5'h01;
            if (dummy_done) begin
              st <= ST_DATA;
            end
          end
          ST_STATUS_WRITE_CMD: begin
            if (cnt < STATUS_WRITE_CMD_BITS_SHORT) begin
              wr_sh <= {wr_sh[6:0], s_io[0]};
            end
            cnt <= cnt_sat;
          end
          ST_HOLD: begin
            cnt <= cnt_sat;
          end
          default: begin
          end
        endcase
      end else if (shifting) begin
        io_line_o <= {out_byte[7], dual ? out_byte[6] : 1'b0};
        io_line_oe_o <= {1'b1, dual};
        byte_sh <= dual ? {out_byte[5:0], 2'b00} : {out_byte[6:0], 1'b0};
        left <= next_left;
        if ((left == 4'h0) && (st == ST_DATA)) begin
          mem_addr <= mem_addr + 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status register and timed write cycle
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      status_write_disable <= STATUS_RESET[SB_STATUS_WRITE_DISABLE];
      quad_enable <= STATUS_RESET[SB_QUAD_ENABLE];
      block_protect_bits <= STATUS_RESET[SB_BP_HI:SB_BP_LO];
      write_enable_latch <= STATUS_RESET[SB_WRITE_ENABLE_LATCH];
      write_in_progress <= STATUS_RESET[SB_WRITE_IN_PROGRESS];
      timer <= 32'h0;
    end else if (ce_i) begin
      if (status_write_cmd_ok) begin
        status_write_disable <= wr_sh[SB_STATUS_WRITE_DISABLE];
        quad_enable <= wr_sh[SB_QUAD_ENABLE];
        block_protect_bits <= wr_sh[SB_BP_HI:SB_BP_LO];
        write_in_progress <= 1'b1;
        timer <= 32'(WRITE_CYCLES - 1);
      end else if (write_in_progress) begin
        if (timer == 32'h0) begin
          write_in_progress <= 1'b0;
          write_enable_latch <= 1'b0;
        end else begin
          timer <= timer - 32'h1;
        end
      end
      if (wel_set) begin
        write_enable_latch <= 1'b1;
      end else if (wel_clr) begin
        write_enable_latch <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // protection outputs for program and erase logic
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      status_o <= STATUS_RESET;
      hardware_protect_mode_o <= 1'b0;
      software_protect_mode_o <= 1'b1;
      block_protect_o <= STATUS_RESET[SB_BP_HI:SB_BP_LO];
    end else if (ce_i) begin
      status_o <= status;
      hardware_protect_mode_o <= hardware_protect_mode;
      software_protect_mode_o <= ~hardware_protect_mode;
      block_protect_o <= block_protect_bits;
    end
  end
endmodule

// ===== fsh_checker.sv
module fsh_checker #(
  parameter int unsigned WRITE_CYCLES = 400000
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // watched pins
  input wire logic cs_n_i,
  input wire logic write_protect_pin_n_i,
  input wire logic [1:0] io_line_oe_o,
  input wire logic [7:0] status_o,
  input wire logic hardware_protect_mode_o,
  input wire logic software_protect_mode_o,
  input wire logic [3:0] block_protect_o
);
  timeunit 1ns;
  timeprecision 100ps;
  int unsigned busy_cnt;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////
  // length of the current busy stretch
  always_ff @(posedge mclk_i) begin
    if (rst_i || !status_o[0]) begin
      busy_cnt <= 0;
    end else begin
      busy_cnt <= busy_cnt + 1;
    end
  end
  ////////////////////////////////////////
  spm_inverse_a: assert property (software_protect_mode_o == !hardware_protect_mode_o)
    else $error("protect mode outputs disagree");
  bp_mirror_a: assert property (block_protect_o == status_o[5:2])
    else $error("protect bits differ from status byte");
  oe_idle_a: assert property (cs_n_i [*6] |-> io_line_oe_o == 2'b00)
    else $error("lines driven while deselected");
  oe_shape_a: assert property (io_line_oe_o != 2'b01)
    else $error("single data on the wrong line");
  hpm_entry_a: assert property ((status_o[7] && !status_o[6] && !write_protect_pin_n_i) [*6]
    |-> hardware_protect_mode_o) else $error("hardware protection not entered");
  hpm_exit_a: assert property (write_protect_pin_n_i [*6] |-> !hardware_protect_mode_o)
    else $error("hardware protection kept with pin high");
  quad_no_hpm_a: assert property (status_o[6] |-> !hardware_protect_mode_o)
    else $error("hardware protection with quad enabled");
  busy_latch_a: assert property ($rose(status_o[0]) |-> status_o[1])
    else $error("latch lost at start of write");
  busy_end_a: assert property ($fell(status_o[0]) |-> !status_o[1])
    else $error("latch not cleared at end of write");
  busy_len_a: assert property ($fell(status_o[0]) |-> busy_cnt == WRITE_CYCLES)
    else $error("write cycle length wrong");
  hpm_freeze_a: assert property (hardware_protect_mode_o [*2] |-> $stable(status_o[7:2]))
    else $error("status changed under hardware protection");
endmodule

// ===== fsh_host_model.sv
module fsh_host_model (
  // device side
  input wire logic [1:0] dev_o_i,
  input wire logic [1:0] dev_oe_i,
  // link pins
  output logic cs_n_o,
  output logic sclk_o,
  output logic [1:0] io_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] drv = 2'b00;
  logic [1:0] drv_oe = 2'b00;
  logic flt = 1'b0;
  initial cs_n_o = 1'b1;
  initial sclk_o = 1'b0;
  // undriven lines wander instead of keeping the last level
  always #35 flt = ~flt;
  assign io_o[0] = dev_oe_i[0] ? dev_o_i[0] : (drv_oe[0] ? drv[0] : flt);
  assign io_o[1] = dev_oe_i[1] ? dev_o_i[1] : (drv_oe[1] ? drv[1] : ~flt);
  ////////////////////////////////////////
  task automatic open_frame();
    cs_n_o = 1'b0;
    #100;
  endtask
  // deselect only after the last clock has fallen
  task automatic close_frame();
    drv_oe = 2'b00;
    #60;
    cs_n_o = 1'b1;
    #150;
  endtask
  // n clocks, msb first; bits change while the clock is low
  task automatic shift(input logic [31:0] v, input int n, input bit dual, input bit drive,
                       output logic [31:0] got);
    got = '0;
    for (int i = 0; i < n; i++) begin
      drv = dual ? v[2*(n-1-i) +: 2] : {1'b0, v[n-1-i]};
      drv_oe = drive ? (dual ? 2'b11 : 2'b01) : 2'b00;
      #100;
      sclk_o = 1'b1;
      got = dual ? {got[29:0], io_o} : {got[30:0], io_o[1]};
      #100;
      sclk_o = 1'b0;
    end
  endtask
endmodule

// ===== testbench.sv
module testbench;
  import fsh_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {logic [7:0] op; logic [23:0] addr; logic [7:0] first;} fsh_row_s;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic wp_n = 1'b1;
  logic mem_load = 1'b0;
  logic [7:0] mem_addr = 8'h00;
  logic [7:0] mem_data = 8'h00;
  logic cs_n, sclk;
  logic [1:0] io_line, io_line_o, io_line_oe_o;
  logic [7:0] status_o, s;
  logic hardware_protect_mode, software_protect_mode;
  logic [3:0] bp;
  int fail_count = 0;
  int compares = 0;
  fsh_row_s rows [5] = '{'{OP_READ, 24'h12347F, 8'hDA}, '{OP_FAST_READ, 24'h0000FE, 8'h5B},
    '{OP_DUAL_OUT_READ, 24'h000040, 8'hE5}, '{OP_DUAL_IO_READ, 24'hA5A5FF, 8'h5A},
    '{OP_READ, 24'h0000FF, 8'h5A}};
  initial forever #12.5 mclk_i = ~mclk_i;
  fsh_host_model i_host (.dev_o_i(io_line_o), .dev_oe_i(io_line_oe_o), .cs_n_o(cs_n),
    .sclk_o(sclk), .io_o(io_line));
  fsh_flash_core #(.AW(8), .WRITE_CYCLES(2000)) i_dut (.mclk_i(mclk_i), .rst_i(rst_i),
    .ce_i(ce_i), .cs_n_i(cs_n), .sclk_i(sclk), .io_line_i(io_line),
    .write_protect_pin_n_i(wp_n), .io_line_o(io_line_o), .io_line_oe_o(io_line_oe_o),
    .mem_load_i(mem_load), .mem_load_addr_i(mem_addr), .mem_load_data_i(mem_data),
    .status_o(status_o), .hardware_protect_mode_o(hardware_protect_mode), .software_protect_mode_o(software_protect_mode),
    .block_protect_o(bp));
  ////////////////////////////////////////
  function automatic logic [7:0] pat(input logic [7:0] a);
    return a ^ 8'hA5;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s: expected %0h, seen %0h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic cmd(input logic [7:0] op, input logic [31:0] d, input int n);
    logic [31:0] g;
    i_host.open_frame();
    i_host.shift(32'(op), 8, 1'b0, 1'b1, g);
    if (n > 0) i_host.shift(d, n, 1'b0, 1'b1, g);
    i_host.close_frame();
  endtask
  task automatic rd_status(output logic [7:0] st);
    logic [31:0] g;
    i_host.open_frame();
    i_host.shift(32'(OP_READ_STATUS), 8, 1'b0, 1'b1, g);
    i_host.shift(32'h0, 8, 1'b0, 1'b0, g);
    i_host.close_frame();
    st = g[7:0];
  endtask
  task automatic wait_idle(output logic [7:0] st);
    for (int i = 0; i < 20; i++) begin
      rd_status(st);
      if (st[0] === 1'b0) break;
    end
  endtask
  task automatic read_chk(input fsh_row_s r, input bit ok);
    logic [31:0] g;
    bit dio;
    bit dd;
    dio = (r.op == OP_DUAL_IO_READ);
    dd = dio || (r.op == OP_DUAL_OUT_READ);
    i_host.open_frame();
    i_host.shift(32'(r.op), 8, 1'b0, 1'b1, g);
    i_host.shift(32'(r.addr), dio ? 12 : 24, dio, 1'b1, g);
    if (r.op != OP_READ) i_host.shift(32'h0, dio ? 4 : 8, dio, 1'b1, g);
    for (int k = 0; k < 3; k++) begin
      i_host.shift(32'h0, dd ? 4 : 8, dd, 1'b0, g);
      if (ok) check(g[7:0], k == 0 ? r.first : pat(r.addr[7:0] + 8'(k)), "data");
      check(io_line_oe_o, !ok ? 2'b00 : (dd ? 2'b11 : 2'b10), "enable");
    end
    i_host.close_frame();
  endtask
  task automatic wp_set(input logic v, input logic exp_hpm);
    @(posedge mclk_i) wp_n <= v;
    repeat (10) @(posedge mclk_i);
    check(hardware_protect_mode, exp_hpm, "hardware protect");
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (4) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(posedge mclk_i);
    check({status_o, hardware_protect_mode, software_protect_mode}, 10'h001, "reset state");
    for (int i = 0; i < 256; i++) begin
      @(posedge mclk_i);
      mem_load <= 1'b1;
      mem_addr <= 8'(i);
      mem_data <= pat(8'(i));
    end
    @(posedge mclk_i) mem_load <= 1'b0;
    #7;
    foreach (rows[i]) read_chk(rows[i], 1'b1);
    $display("test reads finished");
    cmd(OP_WRITE_STATUS, 32'h3C, 8);
    rd_status(s);
    check(s, 8'h00, "status no latch");
    cmd(OP_WRITE_ENABLE, 32'h0, 0);
    cmd(OP_WRITE_STATUS, 32'h118, 9);
    rd_status(s);
    check(s, 8'h02, "status odd length");
    cmd(OP_WRITE_ENABLE, 32'h0, 0);
    cmd(OP_WRITE_STATUS, 32'h8C00, 16);
    rd_status(s);
    check(s, 8'h8F, "status while busy");
    for (int i = 1; i < 4; i++) read_chk(rows[i], 1'b0);
    wait_idle(s);
    check({s, bp}, 12'h8C3, "status after write");
    $display("test status write finished");
    wp_set(1'b0, 1'b1);
    cmd(OP_WRITE_ENABLE, 32'h0, 0);
    cmd(OP_WRITE_STATUS, 32'h00, 8);
    rd_status(s);
    check(s, 8'h8E, "status in protection");
    wp_set(1'b1, 1'b0);
    cmd(OP_WRITE_ENABLE, 32'h0, 0);
    cmd(OP_WRITE_STATUS, 32'h40, 8);
    wait_idle(s);
    check(s, 8'h40, "status pin high");
    wp_set(1'b0, 1'b0);
    cmd(OP_WRITE_ENABLE, 32'h0, 0);
    cmd(OP_WRITE_STATUS, 32'hC4, 8);
    wait_idle(s);
    check({s, hardware_protect_mode}, 9'h188, "status quad set");
    $display("test protection finished");
    @(posedge mclk_i) rst_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(posedge mclk_i);
    check(status_o, 8'h00, "status after reset");
    cmd(OP_WRITE_ENABLE, 32'h0, 0);
    cmd(OP_WRITE_STATUS, 32'h80, 8);
    wait_idle(s);
    repeat (10) @(posedge mclk_i);
    check({s, hardware_protect_mode}, 9'h101, "pin low first");
    $display("test second reset finished");
    conclude();
  end
  initial begin
    #1000000;
    fail_count++;
    conclude();
  end
endmodule

bind fsh_flash_core fsh_checker #(.WRITE_CYCLES(WRITE_CYCLES)) i_chk (.mclk_i, .rst_i, .cs_n_i,
  .write_protect_pin_n_i, .io_line_oe_o, .status_o, .hardware_protect_mode_o,
  .software_protect_mode_o, .block_protect_o);
